// [design/lcm_ctrl.v]
// l1 cache maintenance and access control register block
// assumes the core drives the register port on CLK, holding a request until its ack
`timescale 1ns/10ps
`include "lcm_map.vh"
module lcm_ctrl #(
    parameter D_WAYS_LOG2 = 2,
    parameter D_SETS_LOG2 = 9,
    parameter I_WAYS_LOG2 = 1,
    parameter I_SETS_LOG2 = 9,
    parameter ECC_PRESENT = 0
) (
    // clock and reset
    input  wire                   CLK,
    input  wire                   RST,
    // register port
    input  wire                   REG_REQ,
    input  wire                   REG_WR,
    input  wire [31:0]            REG_ADDR,
    input  wire [31:0]            REG_WDATA,
    input  wire                   REG_PRIV,
    output reg                    REG_ACK,
    output reg  [31:0]            REG_RDATA,
    output reg                    REG_ERR,
    // barrier
    input  wire                   SYNC_REQ,
    output reg                    SYNC_DONE,
    // faults
    input  wire                   MAINT_ERR_PIN,
    input  wire                   BUS_ERR_HANDLER_EN,
    input  wire                   BUS_ERR_TAKEN,
    output reg                    BUS_ERR_PEND,
    output reg                    ESCALATE,
    output reg                    LOCKUP,
    // control outputs
    output reg                    DCACHE_EN,
    output reg                    ICACHE_EN,
    output reg  [31:0]            ITCM_CTRL,
    output reg  [31:0]            DTCM_CTRL,
    output reg  [31:0]            PPORT_CTRL,
    output reg  [31:0]            AUX_CACHE_CTRL,
    output reg  [31:0]            SLAVE_CTRL,
    output reg                    MAINT_BUSY,
    // line fill and lookup
    input  wire                   FILL_EN,
    input  wire                   FILL_ICACHE,
    input  wire [D_SETS_LOG2-1:0] FILL_SET,
    input  wire [D_WAYS_LOG2-1:0] FILL_WAY,
    input  wire                   LOOK_ICACHE,
    input  wire [D_SETS_LOG2-1:0] LOOK_SET,
    input  wire [D_WAYS_LOG2-1:0] LOOK_WAY,
    output reg                    LOOK_VALID
);
    reg         ack_q, err_q, sync_q, pend_q, esc_q, lock_q, busy_q, look_q;
    reg  [31:0] rdata_q, rdata_d;
    reg  [31:0] cfg_q, itcm_q, dtcm_q, pport_q, auxcc_q, slave_q, fstat_q;
    reg         sel_q, sweep_q, err_s1_q, err_s2_q;
    wire        ic_busy, dc_busy, ic_look, dc_look;

    // size id word for a cache with the given geometry, 8-word lines
    function [31:0] size_id;
        input [31:0] ways_log2;
        input [31:0] sets_log2;
        reg   [31:0] ways_m1;
        reg   [31:0] sets_m1;
        begin
            ways_m1 = (32'h1 << ways_log2) - 32'h1;
            sets_m1 = (32'h1 << sets_log2) - 32'h1;
            size_id = (sets_m1 << `LCM_SIZE_ID_SET_LSB) | (ways_m1 << `LCM_SIZE_ID_WAY_LSB) | `LCM_SIZE_ID_LINE;
        end
    endfunction

    function is_addr;
        input [31:0] a;
        input [31:0] b;
        begin
            is_addr = (a == b);
        end
    endfunction

    // ****************************************************************
    // request decode
    // ****************************************************************
    wire maint_hit = (REG_ADDR >= `LCM_ADDR_MAINT_FIRST) && (REG_ADDR <= `LCM_ADDR_MAINT_LAST);
    wire busy      = ic_busy | dc_busy | sweep_q;
    // a maintenance write waits for the previous one: strict issue order
    wire stall     = REG_WR & REG_PRIV & maint_hit & busy;
    wire take      = REG_REQ & ~ack_q & ~stall;
    wire priv_wr   = take & REG_WR & REG_PRIV;
    wire op_issue  = priv_wr & maint_hit;

    wire ic_inv_all = op_issue & is_addr(REG_ADDR, `LCM_ADDR_IC_INV_ALL);
    wire ic_inv_set = op_issue & is_addr(REG_ADDR, `LCM_ADDR_IC_INV_ADDR);
    wire dc_inv_set = op_issue & (is_addr(REG_ADDR, `LCM_ADDR_DC_INV_ADDR) | is_addr(REG_ADDR, `LCM_ADDR_DC_CI_ADDR));
    wire dc_inv_sw  = op_issue & (is_addr(REG_ADDR, `LCM_ADDR_DC_INV_SW) | is_addr(REG_ADDR, `LCM_ADDR_DC_CI_SW));

    wire [D_WAYS_LOG2-1:0] sw_way = REG_WDATA[`LCM_SW_WAY_LSB +: D_WAYS_LOG2];
    wire [D_SETS_LOG2-1:0] sw_set = REG_WDATA[`LCM_SW_SET_LSB +: D_SETS_LOG2];
    wire [D_SETS_LOG2-1:0] ad_set = REG_WDATA[`LCM_ADDR_SET_LSB +: D_SETS_LOG2];
    wire [I_SETS_LOG2-1:0] ia_set = REG_WDATA[`LCM_ADDR_SET_LSB +: I_SETS_LOG2];

    // line operations finish on issue, the sweep when the array goes idle
    wire maint_done = (op_issue & ~ic_inv_all) | (sweep_q & ~ic_inv_all & ~ic_busy);
    wire fault_ev   = maint_done & err_s2_q;

    // ****************************************************************
    // cache valid arrays
    // ****************************************************************
    lcm_line_valid #(
        .WAYS_LOG2 (I_WAYS_LOG2),
        .SETS_LOG2 (I_SETS_LOG2)
    ) u_icache (
        .clk           (CLK),
        .rst           (RST),
        .fill_en       (FILL_EN & FILL_ICACHE),
        .fill_set      (FILL_SET[I_SETS_LOG2-1:0]),
        .fill_way      (FILL_WAY[I_WAYS_LOG2-1:0]),
        .inv_all       (ic_inv_all),
        .inv_en        (ic_inv_set),
        .inv_whole_set (1'b1),
        .inv_set       (ia_set),
        .inv_way       ({I_WAYS_LOG2{1'b0}}),
        .busy          (ic_busy),
        .look_set      (LOOK_SET[I_SETS_LOG2-1:0]),
        .look_way      (LOOK_WAY[I_WAYS_LOG2-1:0]),
        .look_valid    (ic_look)
    );

    lcm_line_valid #(
        .WAYS_LOG2 (D_WAYS_LOG2),
        .SETS_LOG2 (D_SETS_LOG2)
    ) u_dcache (
        .clk           (CLK),
        .rst           (RST),
        .fill_en       (FILL_EN & ~FILL_ICACHE),
        .fill_set      (FILL_SET),
        .fill_way      (FILL_WAY),
        .inv_all       (1'b0),
        .inv_en        (dc_inv_set | dc_inv_sw),
        .inv_whole_set (dc_inv_set),
        .inv_set       (dc_inv_set ? ad_set : sw_set),
        .inv_way       (sw_way),
        .busy          (dc_busy),
        .look_set      (LOOK_SET),
        .look_way      (LOOK_WAY),
        .look_valid    (dc_look)
    );

    // ****************************************************************
    // read data
    // ****************************************************************
    always @* begin
        rdata_d = `LCM_RST_ZERO;
        case (REG_ADDR)
            `LCM_ADDR_CFG:      rdata_d = cfg_q;
            `LCM_ADDR_SIZE_SEL: rdata_d = {31'h0, sel_q};
            `LCM_ADDR_SIZE_ID:  rdata_d = sel_q ? size_id(I_WAYS_LOG2, I_SETS_LOG2)
                                              : size_id(D_WAYS_LOG2, D_SETS_LOG2);
            `LCM_ADDR_ITCM:   rdata_d = itcm_q;
            `LCM_ADDR_DTCM:   rdata_d = dtcm_q;
            `LCM_ADDR_PPORT:  rdata_d = pport_q;
            `LCM_ADDR_AUXCC:  rdata_d = auxcc_q;
            `LCM_ADDR_SLAVE:  rdata_d = slave_q;
            `LCM_ADDR_FSTAT:  rdata_d = fstat_q;
            default:          rdata_d = `LCM_RST_ZERO;
        endcase
    end

    // ****************************************************************
    // registers
    // ****************************************************************
    always @(posedge CLK or posedge RST) begin
        if (RST) begin
            ack_q    <= 1'b0;
            err_q    <= 1'b0;
            rdata_q  <= `LCM_RST_ZERO;
            cfg_q    <= `LCM_RST_ZERO;
            sel_q    <= 1'b0;
            itcm_q   <= `LCM_RST_ZERO;
            dtcm_q   <= `LCM_RST_ZERO;
            pport_q  <= `LCM_RST_ZERO;
            auxcc_q  <= (ECC_PRESENT != 0) ? `LCM_RST_ZERO : `LCM_RST_AUXCC_NOECC;
            slave_q  <= `LCM_RST_SLAVE;
            fstat_q  <= `LCM_RST_ZERO;
            sweep_q  <= 1'b0;
            err_s1_q <= 1'b0;
            err_s2_q <= 1'b0;
            sync_q   <= 1'b0;
            pend_q   <= 1'b0;
            esc_q    <= 1'b0;
            lock_q   <= 1'b0;
            busy_q   <= 1'b0;
            look_q   <= 1'b0;
        end else begin
            err_s1_q <= MAINT_ERR_PIN;
            err_s2_q <= err_s1_q;
            ack_q    <= take;
            // unprivileged access to maintenance space is refused
            err_q    <= take & ~REG_PRIV & maint_hit;
            rdata_q  <= (take & ~REG_WR & REG_PRIV) ? rdata_d : `LCM_RST_ZERO;
            if (priv_wr) begin
                case (REG_ADDR)
                    `LCM_ADDR_CFG:      cfg_q <= REG_WDATA & `LCM_CFG_WMASK;
                    `LCM_ADDR_SIZE_SEL: sel_q <= REG_WDATA[`LCM_SIZE_SEL_BIT];
                    `LCM_ADDR_ITCM:   itcm_q  <= REG_WDATA & `LCM_TCM_WMASK;
                    `LCM_ADDR_DTCM:   dtcm_q  <= REG_WDATA & `LCM_TCM_WMASK;
                    `LCM_ADDR_PPORT:  pport_q <= REG_WDATA & `LCM_PPORT_WMASK;
                    `LCM_ADDR_AUXCC:  auxcc_q <= REG_WDATA;
                    `LCM_ADDR_SLAVE:  slave_q <= REG_WDATA;
                    default:          sel_q   <= sel_q;
                endcase
            end
            // write one to clear; a fault in the same cycle still sets
            if (fault_ev)
                fstat_q[`LCM_FSTAT_MAINT_BIT] <= 1'b1;
            else if (priv_wr && is_addr(REG_ADDR, `LCM_ADDR_FSTAT) && REG_WDATA[`LCM_FSTAT_MAINT_BIT])
                fstat_q[`LCM_FSTAT_MAINT_BIT] <= 1'b0;
            if (ic_inv_all)
                sweep_q <= 1'b1;
            else if (!ic_busy)
                sweep_q <= 1'b0;
            // barrier waits for every maintenance operation in flight
            sync_q <= SYNC_REQ & ~sync_q & ~busy & ~op_issue;
            if (fault_ev)
                pend_q <= 1'b1;
            else if (BUS_ERR_TAKEN)
                pend_q <= 1'b0;
            esc_q  <= fault_ev & ~BUS_ERR_HANDLER_EN;
            lock_q <= 1'b0;
            busy_q <= busy | ic_inv_all;
            look_q <= LOOK_ICACHE ? ic_look : dc_look;
        end
    end

    // ****************************************************************
    // outputs straight from flops
    // ****************************************************************
    always @* begin
        REG_ACK        = ack_q;
        REG_ERR        = err_q;
        REG_RDATA      = rdata_q;
        SYNC_DONE      = sync_q;
        BUS_ERR_PEND   = pend_q;
        ESCALATE       = esc_q;
        LOCKUP         = lock_q;
        DCACHE_EN      = cfg_q[`LCM_CFG_DC_BIT];
        ICACHE_EN      = cfg_q[`LCM_CFG_IC_BIT];
        ITCM_CTRL      = itcm_q;
        DTCM_CTRL      = dtcm_q;
        PPORT_CTRL     = pport_q;
        AUX_CACHE_CTRL = auxcc_q;
        SLAVE_CTRL     = slave_q;
        MAINT_BUSY     = busy_q;
        LOOK_VALID     = look_q;
    end
endmodule

// [design/lcm_line_valid.v]
// line valid store of one l1 cache, with single-line, whole-set and sweep invalidation
// assumes the caller issues no new invalidation while busy is high
`timescale 1ns/10ps
module lcm_line_valid #(
    parameter WAYS_LOG2 = 2,
    parameter SETS_LOG2 = 9
) (
    input  wire                 clk,
    input  wire                 rst,
    // fill from the line refill logic
    input  wire                 fill_en,
    input  wire [SETS_LOG2-1:0] fill_set,
    input  wire [WAYS_LOG2-1:0] fill_way,
    // maintenance
    input  wire                 inv_all,
    input  wire                 inv_en,
    input  wire                 inv_whole_set,
    input  wire [SETS_LOG2-1:0] inv_set,
    input  wire [WAYS_LOG2-1:0] inv_way,
    output wire                 busy,
    // lookup
    input  wire [SETS_LOG2-1:0] look_set,
    input  wire [WAYS_LOG2-1:0] look_way,
    output wire                 look_valid
);
    localparam WAYS = 1 << WAYS_LOG2;
    localparam SETS = 1 << SETS_LOG2;

    // contents are undefined after reset: software must invalidate first
    reg [WAYS-1:0]      valid_q [0:SETS-1];
    reg                 sweep_q;
    reg [SETS_LOG2-1:0] sweep_set_q;

    function [WAYS-1:0] way_bit;
        input [WAYS_LOG2-1:0] w;
        begin
            way_bit = {{(WAYS-1){1'b0}}, 1'b1} << w;
        end
    endfunction

    assign busy       = sweep_q;
    assign look_valid = valid_q[look_set][look_way];

    // ****************************************************************
    // sweep: one set per cycle
    // ****************************************************************
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            sweep_q     <= 1'b0;
            sweep_set_q <= {SETS_LOG2{1'b0}};
        end else if (inv_all) begin
            sweep_q     <= 1'b1;
            sweep_set_q <= {SETS_LOG2{1'b0}};
        end else if (sweep_q) begin
            sweep_q     <= (sweep_set_q != {SETS_LOG2{1'b1}});
            sweep_set_q <= sweep_set_q + {{(SETS_LOG2-1){1'b0}}, 1'b1};
        end
    end

    // ****************************************************************
    // storage; invalidation is written last so it wins over a fill
    // ****************************************************************
    always @(posedge clk) begin
        if (fill_en)
            valid_q[fill_set] <= valid_q[fill_set] | way_bit(fill_way);
        if (inv_en)
            valid_q[inv_set] <= inv_whole_set ? {WAYS{1'b0}} : (valid_q[inv_set] & ~way_bit(inv_way));
        if (sweep_q)
            valid_q[sweep_set_q] <= {WAYS{1'b0}};
    end
endmodule

// [design/lcm_map.vh]
// register map, field positions and reset values of the l1 cache maintenance block
// assumes a 32-bit privileged register port carrying full byte addresses
`ifndef LCM_MAP_VH
`define LCM_MAP_VH

// ****************************************************************
// register addresses
// ****************************************************************
`define LCM_ADDR_CFG         32'he000ed14
`define LCM_ADDR_SIZE_ID     32'he000ed80
`define LCM_ADDR_SIZE_SEL    32'he000ed84
`define LCM_ADDR_IC_INV_ALL  32'he000ef50
`define LCM_ADDR_IC_INV_ADDR 32'he000ef58
`define LCM_ADDR_DC_INV_ADDR 32'he000ef5c
`define LCM_ADDR_DC_INV_SW   32'he000ef60
`define LCM_ADDR_DC_CLN_UNIF 32'he000ef64
`define LCM_ADDR_DC_CLN_COH  32'he000ef68
`define LCM_ADDR_DC_CLN_SW   32'he000ef6c
`define LCM_ADDR_DC_CI_ADDR  32'he000ef70
`define LCM_ADDR_DC_CI_SW    32'he000ef74
`define LCM_ADDR_MAINT_FIRST 32'he000ef50
`define LCM_ADDR_MAINT_LAST  32'he000ef7c
`define LCM_ADDR_ITCM        32'he000ef90
`define LCM_ADDR_DTCM        32'he000ef94
`define LCM_ADDR_PPORT       32'he000ef98
`define LCM_ADDR_AUXCC       32'he000ef9c
`define LCM_ADDR_SLAVE       32'he000efa0
`define LCM_ADDR_FSTAT       32'he000efa8

// ****************************************************************
// fields
// ****************************************************************
`define LCM_CFG_DC_BIT       16
`define LCM_CFG_IC_BIT       17
`define LCM_CFG_WMASK        32'h0003_0000
`define LCM_SIZE_SEL_BIT     0
`define LCM_SW_WAY_LSB       30
`define LCM_SW_SET_LSB       5
`define LCM_ADDR_SET_LSB     5
`define LCM_SIZE_ID_WAY_LSB  3
`define LCM_SIZE_ID_SET_LSB  13
`define LCM_SIZE_ID_LINE     32'h0000_0001
`define LCM_TCM_WMASK        32'h0000_0007
`define LCM_PPORT_WMASK      32'h0000_0001
`define LCM_FSTAT_MAINT_BIT  0

// ****************************************************************
// reset values
// ****************************************************************
`define LCM_RST_ZERO         32'h0000_0000
`define LCM_RST_SLAVE        32'h0000_0800
`define LCM_RST_AUXCC_NOECC  32'h0000_0002

`endif

// [sim/lcm_ctrl_asserts.sv]
// port assertions for the l1 cache maintenance block
// assumes a bind to lcm_ctrl with its default cache sizes
`timescale 1ns/10ps
`include "lcm_map.vh"
module lcm_ctrl_asserts #(
    parameter ECC_PRESENT = 0
) (
    // clock and reset
    input wire        CLK,
    input wire        RST,
    // register port
    input wire        REG_REQ,
    input wire        REG_WR,
    input wire [31:0] REG_ADDR,
    input wire [31:0] REG_WDATA,
    input wire        REG_PRIV,
    input wire        REG_ACK,
    input wire [31:0] REG_RDATA,
    input wire        REG_ERR,
    // barrier, faults and controls
    input wire        SYNC_DONE,
    input wire        BUS_ERR_HANDLER_EN,
    input wire        ESCALATE,
    input wire        LOCKUP,
    input wire        DCACHE_EN,
    input wire        ICACHE_EN,
    input wire [31:0] SLAVE_CTRL,
    input wire [31:0] AUX_CACHE_CTRL,
    input wire        MAINT_BUSY
);
    // ****************************************************************
    // helpers and assertions
    // ****************************************************************
    // a request is only taken while no answer is on the port
    wire take     = REG_REQ && !REG_ACK;
    wire in_maint = REG_ADDR >= `LCM_ADDR_MAINT_FIRST && REG_ADDR <= `LCM_ADDR_MAINT_LAST;
    wire unpriv_m = !REG_PRIV && in_maint;

    default clocking @(posedge CLK); endclocking
    default disable iff (RST);

    chk_slave_reset: assert property (disable iff (1'b0) RST |-> SLAVE_CTRL == `LCM_RST_SLAVE)
        else $error("slave control reset value");
    chk_aux_reset: assert property (disable iff (1'b0) RST |->
        AUX_CACHE_CTRL == (ECC_PRESENT ? `LCM_RST_ZERO : `LCM_RST_AUXCC_NOECC)) else $error("aux reset value");
    chk_unpriv_error: assert property (take && unpriv_m |=> REG_ACK && REG_ERR)
        else $error("unprivileged access not refused");
    chk_err_cause: assert property (REG_ERR |-> REG_ACK && $past(unpriv_m))
        else $error("error without cause");
    chk_maint_raz: assert property (take && !REG_WR && in_maint |=> REG_ACK && REG_RDATA == 32'h0)
        else $error("maintenance read not zero");
    chk_enable_bits: assert property (take && REG_WR && REG_PRIV && REG_ADDR == `LCM_ADDR_CFG |=>
        DCACHE_EN == $past(REG_WDATA[16]) && ICACHE_EN == $past(REG_WDATA[17])) else $error("enable bits");
    chk_sweep_busy: assert property (take && REG_WR && REG_PRIV && REG_ADDR == `LCM_ADDR_IC_INV_ALL &&
        !MAINT_BUSY |-> ##2 MAINT_BUSY [*8]) else $error("sweep not busy");
    chk_sync_after: assert property (SYNC_DONE |-> !MAINT_BUSY)
        else $error("barrier done while busy");
    chk_no_lockup: assert property (!LOCKUP)
        else $error("lockup raised");
    chk_no_escalate: assert property (BUS_ERR_HANDLER_EN && $past(BUS_ERR_HANDLER_EN) |-> !ESCALATE)
        else $error("escalation with handler on");
endmodule

// [sim/tb_top.sv]
// self-checking bench for the l1 cache maintenance block
// assumes lcm_ctrl with default sizes: dcache 4x512, icache 2x512
`timescale 1ns/10ps
`include "lcm_map.vh"
module tb_top;
    logic        clk = 1'b0, rst = 1'b0, req = 0, wr = 0, priv = 1, bar = 0, pin = 0, hen = 1, taken = 0;
    logic        fill = 0, fic = 0, lic = 0, e;
    logic [31:0] addr = 0, wdata = 0, rd, r, seed = 32'h0001_1344;
    logic [8:0]  fset = 0, lset = 0;
    logic [1:0]  fway = 0, lway = 0;
    wire         ack, err, done, pend, esc, lock, dcen, icen, busy, lval;
    wire  [31:0] rdata, itcm, dtcm, pport, aux, slave;
    int          error_cnt = 0, n_compared = 0, esc_seen = 0, n;
    localparam logic [31:0] RA [0:6] = '{`LCM_ADDR_ITCM, `LCM_ADDR_DTCM, `LCM_ADDR_PPORT, `LCM_ADDR_AUXCC,
        `LCM_ADDR_SLAVE, `LCM_ADDR_FSTAT, `LCM_ADDR_CFG};
    localparam logic [31:0] RV [0:6] = '{32'h0, 32'h0, 32'h0, 32'h2, 32'h800, 32'h0, 32'h0};
    localparam logic [31:0] RM [0:4] = '{32'h7, 32'h7, 32'h1, 32'hffffffff, 32'hffffffff};

    lcm_ctrl i_dut (.CLK(clk), .RST(rst), .REG_REQ(req), .REG_WR(wr), .REG_ADDR(addr), .REG_WDATA(wdata),
        .REG_PRIV(priv), .REG_ACK(ack), .REG_RDATA(rdata), .REG_ERR(err), .SYNC_REQ(bar), .SYNC_DONE(done),
        .MAINT_ERR_PIN(pin), .BUS_ERR_HANDLER_EN(hen), .BUS_ERR_TAKEN(taken), .BUS_ERR_PEND(pend),
        .ESCALATE(esc), .LOCKUP(lock), .DCACHE_EN(dcen), .ICACHE_EN(icen), .ITCM_CTRL(itcm), .DTCM_CTRL(dtcm),
        .PPORT_CTRL(pport), .AUX_CACHE_CTRL(aux), .SLAVE_CTRL(slave), .MAINT_BUSY(busy), .FILL_EN(fill),
        .FILL_ICACHE(fic), .FILL_SET(fset), .FILL_WAY(fway), .LOOK_ICACHE(lic), .LOOK_SET(lset),
        .LOOK_WAY(lway), .LOOK_VALID(lval));

    always #5 clk = ~clk;
    always @(posedge clk) if (esc === 1'b1) esc_seen++;

    // ****************************************************************
    // bench tasks
    // ****************************************************************
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value %s: expected %h, seen %h", what, exp, got);
        end
    endtask
    // request held until the ack edge; stalled maintenance writes may take a whole sweep
    task automatic reg_op(input logic w, input logic p, input logic [31:0] a, input logic [31:0] d);
        int k;
        @(posedge clk);
        #1;
        {req, wr, priv, addr, wdata} = {1'b1, w, p, a, d};
        k = 0;
        do begin
            @(posedge clk);
            #1;
            k++;
        end while (ack !== 1'b1 && k < 2000);
        rd = rdata;
        e = err;
        req = 0;
        if (k >= 2000) check("reg ack", 1, 0);
    endtask
    task automatic barrier();
        @(posedge clk);
        #1;
        bar = 1;
        n = 0;
        do begin
            @(posedge clk);
            #1;
            n++;
        end while (done !== 1'b1 && n < 2000);
        bar = 0;
        if (n >= 2000) check("barrier done", 1, 0);
    endtask
    task automatic fill_line(input logic ic, input logic [8:0] s, input logic [1:0] w);
        @(posedge clk);
        #1;
        {fill, fic, fset, fway} = {1'b1, ic, s, w};
        @(posedge clk);
        #1;
        fill = 0;
    endtask
    task automatic look(input logic ic, input logic [8:0] s, input logic [1:0] w);
        {lic, lset, lway} = {ic, s, w};
        @(posedge clk);
        #1;
    endtask
    task automatic report_and_stop();
        $display("comparisons %0d, mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // ****************************************************************
    // tests
    // ****************************************************************
    initial begin
        // a full run is about 15000 cycles; allow twice that
        #300000;
        error_cnt++;
        report_and_stop();
    end
    initial begin
        // raised after time zero so the asynchronous reset sees a rising edge
        #1;
        rst = 1'b1;
        repeat (3) @(posedge clk);
        #1;
        rst = 0;
        for (int i = 0; i < 7; i++) begin
            reg_op(1, 0, RA[i], 32'hffffffff);
            reg_op(0, 1, RA[i], 32'h0);
            check("reset value", RV[i], rd);
        end
        check("aux port", 32'h2, aux);
        $display("test reset done");
        // invalidate both caches before any enable; barrier first and after
        barrier();
        reg_op(1, 1, `LCM_ADDR_IC_INV_ALL, rnd());
        barrier();
        check("barrier wait", 1, 32'(n > 500));
        for (int w = 0; w < 4; w++)
            for (int s = 0; s < 512; s++)
                reg_op(1, 1, `LCM_ADDR_DC_INV_SW, {w[1:0], 16'h0, s[8:0], 5'h0});
        barrier();
        repeat (8) begin
            r = rnd();
            look(0, r[13:5], r[31:30]);
            check("dcache clear", 1'b0, lval);
            look(1, r[13:5], {1'b0, r[30]});
            check("icache clear", 1'b0, lval);
        end
        repeat (8) begin
            r = rnd();
            fill_line(0, r[13:5], r[31:30]);
            fill_line(0, r[13:5] ^ 9'h1, r[31:30]);
            fill_line(1, r[13:5], {1'b0, r[30]});
            look(0, r[13:5], r[31:30]);
            check("line filled", 1'b1, lval);
            reg_op(1, 1, `LCM_ADDR_DC_INV_SW, r);
            reg_op(1, 1, `LCM_ADDR_IC_INV_ALL, r);
            barrier();
            look(0, r[13:5], r[31:30]);
            check("line dropped", 1'b0, lval);
            look(0, r[13:5] ^ 9'h1, r[31:30]);
            check("neighbour kept", 1'b1, lval);
            look(1, r[13:5], {1'b0, r[30]});
            check("icache swept", 1'b0, lval);
        end
        // self-modifying code: clean to unification, then drop the icache set
        r = rnd();
        fill_line(1, r[13:5], {1'b0, r[30]});
        fill_line(0, r[13:5], r[31:30]);
        barrier();
        reg_op(1, 1, `LCM_ADDR_DC_CLN_UNIF, r);
        reg_op(1, 1, `LCM_ADDR_IC_INV_ADDR, r);
        barrier();
        look(1, r[13:5], {1'b0, r[30]});
        check("icache set dropped", 1'b0, lval);
        look(0, r[13:5], r[31:30]);
        check("clean keeps line", 1'b1, lval);
        reg_op(1, 1, `LCM_ADDR_DC_CI_ADDR, r);
        barrier();
        look(0, r[13:5], r[31:30]);
        check("dcache set dropped", 1'b0, lval);
        // caches off, clean and invalidate every line, caches on again
        reg_op(1, 1, `LCM_ADDR_CFG, 32'h0);
        barrier();
        fill_line(0, r[13:5], r[31:30]);
        for (int w = 0; w < 4; w++)
            for (int s = 0; s < 512; s++)
                reg_op(1, 1, `LCM_ADDR_DC_CI_SW, {w[1:0], 16'h0, s[8:0], 5'h0});
        reg_op(1, 1, `LCM_ADDR_IC_INV_ALL, 32'h0);
        barrier();
        look(0, r[13:5], r[31:30]);
        check("cleaned and dropped", 1'b0, lval);
        reg_op(1, 1, `LCM_ADDR_CFG, 32'h0003_0000);
        barrier();
        check("caches on", 32'h3, {30'h0, icen, dcen});
        $display("test invalidate done");
        reg_op(1, 1, `LCM_ADDR_SIZE_SEL, 32'h0);
        reg_op(0, 1, `LCM_ADDR_SIZE_ID, 32'h0);
        check("dcache size", {4'h0, 15'h1ff, 10'h3, 3'h1}, rd);
        reg_op(1, 1, `LCM_ADDR_SIZE_SEL, 32'h1);
        reg_op(0, 1, `LCM_ADDR_SIZE_ID, 32'h0);
        check("icache size", {4'h0, 15'h1ff, 10'h1, 3'h1}, rd);
        repeat (6) begin
            r = rnd();
            reg_op(1, 1, `LCM_ADDR_CFG, r);
            check("enables", {30'h0, r[17:16]}, {30'h0, icen, dcen});
        end
        for (int i = 0; i < 5; i++) begin
            r = rnd();
            reg_op(1, 1, RA[i], r);
            reg_op(0, 1, RA[i], 32'h0);
            check("access reg", r & RM[i], rd);
            check("port", r & RM[i], i < 1 ? itcm : i < 2 ? dtcm : i < 3 ? pport : i < 4 ? aux : slave);
        end
        reg_op(0, 1, 32'he000efa4, 32'h0);
        check("unmapped", 32'h0, {rd[30:0], e});
        foreach (RA[i]) if (i < 3) begin
            reg_op(0, 1, `LCM_ADDR_IC_INV_ALL + 32'(i * 8), 32'h0);
            check("maint read", 32'h0, rd);
            reg_op(i[0], 0, `LCM_ADDR_DC_INV_SW + 32'(i * 4), rnd());
            check("unpriv error", 1'b1, e);
        end
        $display("test registers done");
        pin = 1;
        repeat (3) @(posedge clk);
        reg_op(1, 1, `LCM_ADDR_DC_INV_ADDR, 32'h0);
        barrier();
        repeat (3) @(posedge clk);
        check("fault pending", 1'b1, pend);
        check("no escalation", 0, esc_seen);
        check("no lockup", 1'b0, lock);
        reg_op(0, 1, `LCM_ADDR_FSTAT, 32'h0);
        check("fault status", 1'b1, rd[0]);
        pin = 0;
        taken = 1;
        @(posedge clk);
        #1;
        taken = 0;
        reg_op(1, 1, `LCM_ADDR_FSTAT, 32'h1);
        reg_op(0, 1, `LCM_ADDR_FSTAT, 32'h0);
        check("fault cleared", 32'h0, {rd[31:1], rd[0] | pend});
        hen = 0;
        pin = 1;
        repeat (3) @(posedge clk);
        reg_op(1, 1, `LCM_ADDR_DC_CLN_SW, 32'h0);
        barrier();
        repeat (3) @(posedge clk);
        check("escalation", 1, esc_seen);
        pin = 0;
        $display("test faults done");
        report_and_stop();
    end
endmodule

bind lcm_ctrl lcm_ctrl_asserts #(.ECC_PRESENT(ECC_PRESENT)) u_chk (.CLK(CLK), .RST(RST), .REG_REQ(REG_REQ),
    .REG_WR(REG_WR), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_PRIV(REG_PRIV), .REG_ACK(REG_ACK),
    .REG_RDATA(REG_RDATA), .REG_ERR(REG_ERR), .SYNC_DONE(SYNC_DONE), .BUS_ERR_HANDLER_EN(BUS_ERR_HANDLER_EN),
    .ESCALATE(ESCALATE), .LOCKUP(LOCKUP), .DCACHE_EN(DCACHE_EN), .ICACHE_EN(ICACHE_EN),
    .SLAVE_CTRL(SLAVE_CTRL), .AUX_CACHE_CTRL(AUX_CACHE_CTRL), .MAINT_BUSY(MAINT_BUSY));
